// ===== rtl/isd_detect.sv
// Input source type detection sequencer with its register file
//
// Functional notes
// - Detection waits until source qualification reports power good.
// - After qualification, detection starts only with auto detect enabled (reset on).
// - Auto detect off skips detection and leaves the current limit untouched.
// - Effective limit is min of register and pin clamp when clamp enabled.
// - Detection results and the reset default, at power good rise, are held to the pin clamp when clamp enabled.
// - Host may rewrite the current limit after detection; it takes effect.
// - Stages run contact detect, primary, secondary, then high voltage.
// - Primary runs BC1.2 classification first, then non-standard divider check.
// - Divider limits: one 2.1 A, two 2 A, three 1 A, four 2.4 A.
// - Secondary stage splits charging ports into downstream or dedicated.
// - BC1.2 done sets status; unmasked also sets flag and pulses interrupt.
// - High voltage handshake needs probe enable and a 9 V or 12 V request.
// - With both requests set, 12 V is tried before 9 V.
// - Detection end clears line status; unmasked sets flag and pulses interrupt.
// - Type codes: SDP 1, CDP 2, DCP 3, HV 4, unknown 5, divider 6.
// - Limits: SDP 500 mA, CDP 1.5 A, DCP 3.25 A, HV 1.5 A, unknown 3 A.
// - HV port first gets DCP limit, then 1.5 A after handshake completes.
// - Host selects plus and minus line drive levels through two registers.
// - Drive level writes are dropped while attached and detection runs.
// - Detection and drive levels act only for the first alternate input.
// - Converter switching starts a fixed 30 ms after detection completes.
`timescale 1ns/1ps
module isd_detect #(
  parameter int unsigned DCD_TMO    = isd_pkg::DCD_TMO_CYC,
  parameter int unsigned HV_TMO     = isd_pkg::HV_TMO_CYC,
  parameter int unsigned SWITCH_DLY = isd_pkg::SWITCH_DLY_CYC
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  // Register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // Analog front end and qualification, asynchronous
  input  wire logic       SRC_QUAL_OK,
  input  wire logic       ATTACH,
  input  wire logic       FIRST_ALT_INPUT,
  input  wire logic       CONTACT_CMP,
  input  wire logic       PRIM_CMP,
  input  wire logic       SEC_CMP,
  input  wire logic       HV_ACK,
  input  wire logic [2:0] DIV_CODE,
  // Pin clamp from the converter ADC, same clock
  input  wire logic [7:0] CLAMP_CODE,
  // Outputs
  output logic      [2:0] PLUS_DRIVE,
  output logic      [2:0] MINUS_DRIVE,
  output logic      [7:0] EFF_LIMIT,
  output logic            SWITCH_EN,
  output logic            INT_PULSE
);

  localparam int NPIN = 10;

  // Three-stage synchronisers; a change counts when stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin_q;
  assign pin_raw = {DIV_CODE, HV_ACK, SEC_CMP, PRIM_CMP, CONTACT_CMP,
                    FIRST_ALT_INPUT, ATTACH, SRC_QUAL_OK};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_q[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  wire       pg_q      = pin_q[0];
  wire       att_q     = pin_q[1];
  wire       first_q   = pin_q[2];
  wire       contact_q = pin_q[3];
  wire       prim_q    = pin_q[4];
  wire       sec_q     = pin_q[5];
  wire       ack_q     = pin_q[6];
  wire [2:0] div_q     = pin_q[9:7];

  // Registers
  isd_pkg::isd_state_e state;
  isd_pkg::isd_state_e next_state;
  logic [7:0]  ctrl;
  logic [7:0]  ilim;
  logic [3:0]  src_type;
  logic        pp_status;
  logic        ld_status;
  logic [1:0]  flags;
  logic [2:0]  plus_lvl;
  logic [2:0]  minus_lvl;
  logic [31:0] cnt;
  logic        att_d;
  logic        pg_d;
  logic        pending;
  logic        dcd_tmo;

  wire auto_en  = ctrl[isd_pkg::CTRL_AUTO];
  wire clamp_en = ctrl[isd_pkg::CTRL_CLAMP];
  wire hv_en    = ctrl[isd_pkg::CTRL_HVEN];
  wire req9     = ctrl[isd_pkg::CTRL_REQ9];
  wire req12    = ctrl[isd_pkg::CTRL_REQ12];
  wire pp_mask  = ctrl[isd_pkg::CTRL_PPMASK];
  wire ld_mask  = ctrl[isd_pkg::CTRL_LDMASK];

  // Clamp never below the lowest legal limit
  wire [7:0] clamp = (CLAMP_CODE < isd_pkg::ILIM_MIN) ? isd_pkg::ILIM_MIN : CLAMP_CODE;

  // Input events
  wire attach_rise = att_q & ~att_d;
  wire pg_rise     = pg_q & ~pg_d;
  wire src_ok      = pg_q & att_q & first_q;

  // Timer compares
  wire settle_end = (cnt >= 32'(isd_pkg::SETTLE_CYC - 1));
  wire dcd_end    = (cnt >= DCD_TMO - 32'd1);
  wire hv_end     = (cnt >= HV_TMO - 32'd1);
  wire sw_end     = (cnt >= SWITCH_DLY - 32'd1);
  wire hv_allowed = hv_en & (req9 | req12);

  // Sequencer decisions
  logic       res_we;
  logic [3:0] res_type;
  logic [7:0] res_ilim;
  logic       bc_evt;
  logic       end_evt;
  logic       skip_evt;

  always_comb begin
    next_state = state;
    res_we     = 1'b0;
    res_type   = src_type;
    res_ilim   = ilim;
    bc_evt     = 1'b0;
    end_evt    = 1'b0;
    skip_evt   = 1'b0;
    unique case (state)
      isd_pkg::S_IDLE: begin
        if (pending && src_ok && auto_en) begin
          next_state = isd_pkg::S_DCD;
        end else if (pending && src_ok) begin
          skip_evt   = 1'b1;
          next_state = isd_pkg::S_WAIT;
        end
      end
      isd_pkg::S_DCD: begin
        if (contact_q || dcd_end) begin
          next_state = isd_pkg::S_PRIM;
        end
      end
      isd_pkg::S_PRIM: begin
        if (settle_end) begin
          next_state = prim_q ? isd_pkg::S_SEC : isd_pkg::S_DIV;
        end
      end
      isd_pkg::S_DIV: begin
        if (settle_end) begin
          res_we     = 1'b1;
          bc_evt     = 1'b1;
          end_evt    = 1'b1;
          next_state = isd_pkg::S_WAIT;
          unique case (div_q)
            3'h1: begin res_type = isd_pkg::TYPE_NSTD; res_ilim = isd_pkg::ILIM_DIV1; end
            3'h2: begin res_type = isd_pkg::TYPE_NSTD; res_ilim = isd_pkg::ILIM_DIV2; end
            3'h3: begin res_type = isd_pkg::TYPE_NSTD; res_ilim = isd_pkg::ILIM_DIV3; end
            3'h4: begin res_type = isd_pkg::TYPE_NSTD; res_ilim = isd_pkg::ILIM_DIV4; end
            default: begin
              res_type = dcd_tmo ? isd_pkg::TYPE_UNK : isd_pkg::TYPE_SDP;
              res_ilim = dcd_tmo ? isd_pkg::ILIM_UNK : isd_pkg::ILIM_SDP;
            end
          endcase
        end
      end
      isd_pkg::S_SEC: begin
        if (settle_end) begin
          res_we   = 1'b1;
          bc_evt   = 1'b1;
          res_type = sec_q ? isd_pkg::TYPE_DCP : isd_pkg::TYPE_CDP;
          res_ilim = sec_q ? isd_pkg::ILIM_DCP : isd_pkg::ILIM_CDP;
          if (sec_q && hv_allowed) begin
            next_state = req12 ? isd_pkg::S_HV12 : isd_pkg::S_HV9;
          end else begin
            end_evt    = 1'b1;
            next_state = isd_pkg::S_WAIT;
          end
        end
      end
      isd_pkg::S_HV12, isd_pkg::S_HV9: begin
        if (ack_q) begin
          res_we     = 1'b1;
          res_type   = isd_pkg::TYPE_HV;
          res_ilim   = isd_pkg::ILIM_HV;
          end_evt    = 1'b1;
          next_state = isd_pkg::S_WAIT;
        end else if (hv_end && state == isd_pkg::S_HV12 && req9) begin
          next_state = isd_pkg::S_HV9;
        end else if (hv_end) begin
          end_evt    = 1'b1;
          next_state = isd_pkg::S_WAIT;
        end
      end
      isd_pkg::S_WAIT: begin
        if (sw_end) begin
          next_state = isd_pkg::S_IDLE;
        end
      end
    endcase
    // New plug-in restarts everything; unplug or lost power good aborts
    if (attach_rise && src_ok && auto_en) begin
      next_state = isd_pkg::S_DCD;
    end else if (!src_ok && !state[0]) begin
      next_state = isd_pkg::S_IDLE;
    end
  end

  wire enter_dcd = (next_state == isd_pkg::S_DCD) && (state != isd_pkg::S_DCD);

  // Sequencer state, timer and edge history
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= isd_pkg::S_IDLE;
      cnt   <= 32'h0000_0000;
      att_d <= 1'b0;
      pg_d  <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= (next_state != state || enter_dcd) ? 32'h0000_0000 : cnt + 32'h0000_0001;
      att_d <= att_q;
      pg_d  <= pg_q;
    end
  end

  // Pending start; lost contact time-out remembered for unknown adapters
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pending <= 1'b0;
      dcd_tmo <= 1'b0;
    end else begin
      // A start must consume the plug-in, or the same adapter is probed again
      if (enter_dcd || skip_evt || !att_q) begin
        pending <= 1'b0;
      end else if (attach_rise) begin
        pending <= 1'b1;
      end
      if (enter_dcd) begin
        dcd_tmo <= 1'b0;
      end else if (state == isd_pkg::S_DCD && !contact_q && dcd_end) begin
        dcd_tmo <= 1'b1;
      end
    end
  end

  // Register write decode
  wire wr_ctrl  = WR && (ADDR == isd_pkg::REG_CTRL);
  wire wr_ilim  = WR && (ADDR == isd_pkg::REG_ILIM);
  wire lvl_lock = att_q && ld_status;
  wire wr_plus  = WR && (ADDR == isd_pkg::REG_PLUS) && !lvl_lock;
  wire wr_minus = WR && (ADDR == isd_pkg::REG_MINUS) && !lvl_lock;
  wire rd_flag  = RD && (ADDR == isd_pkg::REG_FLAG);
  // Minus line has no 0 V or short setting; such codes fall back to open
  wire minus_ok = (WDATA[2:0] >= isd_pkg::DRV_0V6) && (WDATA[2:0] <= isd_pkg::DRV_3V3);
  wire [7:0] host_ilim = (clamp_en && WDATA > clamp) ? clamp : WDATA;
  wire [7:0] det_ilim  = (clamp_en && res_ilim > clamp) ? clamp : res_ilim;
  wire [7:0] pg_ilim   = (clamp_en && ilim > clamp) ? clamp : ilim;

  // Control and level registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl      <= isd_pkg::CTRL_RESET;
      plus_lvl  <= isd_pkg::DRV_HIZ;
      minus_lvl <= isd_pkg::DRV_HIZ;
    end else begin
      if (wr_ctrl) begin
        ctrl <= WDATA;
      end
      if (wr_plus) begin
        plus_lvl <= WDATA[2:0];
      end
      if (wr_minus) begin
        minus_lvl <= minus_ok ? WDATA[2:0] : isd_pkg::DRV_HIZ;
      end
    end
  end

  // Limit and type; detection results win over a same-cycle host write
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ilim     <= isd_pkg::ILIM_RESET;
      src_type <= isd_pkg::TYPE_NONE;
    end else begin
      if (res_we) begin
        ilim     <= det_ilim;
        src_type <= res_type;
      end else if (wr_ilim) begin
        ilim <= host_ilim;
      end else if (pg_rise) begin
        ilim <= pg_ilim;
      end
    end
  end

  // Status, sticky flags and interrupt pulse; a set beats a read clear
  wire pp_set = bc_evt && !pp_mask;
  wire ld_set = end_evt && !ld_mask;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pp_status <= 1'b0;
      ld_status <= 1'b0;
      flags     <= 2'h0;
      INT_PULSE <= 1'b0;
    end else begin
      if (bc_evt) begin
        pp_status <= 1'b1;
      end else if (enter_dcd) begin
        pp_status <= 1'b0;
      end
      if (enter_dcd) begin
        ld_status <= 1'b1;
      end else if (end_evt || next_state == isd_pkg::S_IDLE) begin
        ld_status <= 1'b0;
      end
      flags[isd_pkg::FLAG_PP] <= pp_set | (flags[isd_pkg::FLAG_PP] & ~rd_flag);
      flags[isd_pkg::FLAG_LD] <= ld_set | (flags[isd_pkg::FLAG_LD] & ~rd_flag);
      INT_PULSE <= pp_set | ld_set;
    end
  end

  // Line drive: probe levels during stages, host levels otherwise; both open when not on the first alternate input
  logic [2:0] next_plus;
  logic [2:0] next_minus;
  always_comb begin
    next_plus  = plus_lvl;
    next_minus = minus_lvl;
    unique case (state)
      isd_pkg::S_DCD:  begin next_plus = isd_pkg::DRV_0V6; next_minus = isd_pkg::DRV_HIZ; end
      isd_pkg::S_PRIM: begin next_plus = isd_pkg::DRV_0V6; next_minus = isd_pkg::DRV_HIZ; end
      isd_pkg::S_DIV:  begin next_plus = isd_pkg::DRV_HIZ; next_minus = isd_pkg::DRV_HIZ; end
      isd_pkg::S_SEC:  begin next_plus = isd_pkg::DRV_HIZ; next_minus = isd_pkg::DRV_0V6; end
      isd_pkg::S_HV12: begin next_plus = isd_pkg::DRV_0V6; next_minus = isd_pkg::DRV_0V6; end
      isd_pkg::S_HV9:  begin next_plus = isd_pkg::DRV_3V3; next_minus = isd_pkg::DRV_0V6; end
      default:         begin next_plus = plus_lvl;          next_minus = minus_lvl;        end
    endcase
    if (!first_q) begin
      next_plus  = isd_pkg::DRV_HIZ;
      next_minus = isd_pkg::DRV_HIZ;
    end
  end

  // Read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  wire  [7:0] stat_word = {src_type, 1'b0, ld_status, pp_status, pg_q};
  // Limit in force is the lower of register and clamp when clamp enabled, else the register
  wire  [7:0] eff = (clamp_en && ilim > clamp) ? clamp : ilim;
  always_comb begin
    unique case (ADDR)
      isd_pkg::REG_CTRL:  rd_mux = ctrl;
      isd_pkg::REG_ILIM:  rd_mux = ilim;
      isd_pkg::REG_STAT:  rd_mux = stat_word;
      isd_pkg::REG_FLAG:  rd_mux = {6'h00, flags};
      isd_pkg::REG_PLUS:  rd_mux = {5'h00, plus_lvl};
      isd_pkg::REG_MINUS: rd_mux = {5'h00, minus_lvl};
      isd_pkg::REG_EFF:   rd_mux = eff;
      default:            rd_mux = 8'h00;
    endcase
  end

  // Output flops; converter only runs after the post-detection delay
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA       <= 8'h00;
      PLUS_DRIVE  <= isd_pkg::DRV_HIZ;
      MINUS_DRIVE <= isd_pkg::DRV_HIZ;
      EFF_LIMIT   <= isd_pkg::ILIM_RESET;
      SWITCH_EN   <= 1'b0;
    end else begin
      RDATA       <= RD ? rd_mux : 8'h00;
      PLUS_DRIVE  <= next_plus;
      MINUS_DRIVE <= next_minus;
      EFF_LIMIT   <= eff;
      if (!src_ok || enter_dcd) begin
        SWITCH_EN <= 1'b0;
      end else if (state == isd_pkg::S_WAIT && sw_end) begin
        SWITCH_EN <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  sequence s_bc_unmasked;
    bc_evt && !pp_mask;
  endsequence
  sequence s_flag_and_pulse;
    flags[isd_pkg::FLAG_PP] && INT_PULSE;
  endsequence

  start_after_pg_a: assert property (
    (state == isd_pkg::S_DCD && $past(state) == isd_pkg::S_IDLE) |-> $past(pg_q)
  ) else $error("detection started without power good");

  start_needs_auto_a: assert property (
    (state == isd_pkg::S_DCD && $past(state) != isd_pkg::S_DCD) |-> $past(auto_en)
  ) else $error("detection started with auto detect off");

  skip_keeps_ilim_a: assert property (
    (skip_evt && !wr_ilim && !pg_rise) |=> $stable(ilim) && src_type == $past(src_type)
  ) else $error("skipped detection changed the limit");

  clamp_result_a: assert property (
    (res_we && clamp_en) |=> ilim <= $past(clamp)
  ) else $error("detection limit above clamp");

  eff_limit_a: assert property (
    (clamp_en && ilim > clamp) |=> EFF_LIMIT == $past(clamp)
  ) else $error("effective limit ignores clamp");

  stage_order_a: assert property (
    (state == isd_pkg::S_SEC) |-> $past(state) inside {isd_pkg::S_PRIM, isd_pkg::S_SEC}
  ) else $error("secondary stage entered out of order");

  bc_done_a: assert property (
    s_bc_unmasked |=> s_flag_and_pulse ##0 pp_status
  ) else $error("BC1.2 done not reported");

  hv_gate_a: assert property (
    (state inside {isd_pkg::S_HV12, isd_pkg::S_HV9} && $past(state) == isd_pkg::S_SEC)
      |-> $past(hv_allowed)
  ) else $error("handshake without enable");

  twelve_first_a: assert property (
    (state == isd_pkg::S_HV9 && $past(state) == isd_pkg::S_SEC) |-> !$past(req12)
  ) else $error("9 V tried before 12 V");

  line_done_a: assert property (
    (end_evt && !ld_mask) |=> !ld_status && flags[isd_pkg::FLAG_LD] && INT_PULSE
  ) else $error("detection end not reported");

  level_lock_a: assert property (
    (WR && ADDR == isd_pkg::REG_PLUS && att_q && ld_status) |=> $stable(plus_lvl)
  ) else $error("drive level write not discarded");

  switch_delay_a: assert property (
    $rose(SWITCH_EN) |-> $past(state) == isd_pkg::S_WAIT && $past(cnt) >= SWITCH_DLY - 32'd1
  ) else $error("switching started early");

endmodule

// ===== rtl/isd_pkg.sv
// Constants, register map and state codes for input source type detection
package isd_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_ILIM  = 4'h1;
  localparam logic [3:0] REG_STAT  = 4'h2;
  localparam logic [3:0] REG_FLAG  = 4'h3;
  localparam logic [3:0] REG_PLUS  = 4'h4;
  localparam logic [3:0] REG_MINUS = 4'h5;
  localparam logic [3:0] REG_EFF   = 4'h6;

  // Control register fields
  localparam int CTRL_AUTO   = 0;
  localparam int CTRL_CLAMP  = 1;
  localparam int CTRL_HVEN   = 2;
  localparam int CTRL_REQ9   = 3;
  localparam int CTRL_REQ12  = 4;
  localparam int CTRL_OPTIM  = 5;
  localparam int CTRL_PPMASK = 6;
  localparam int CTRL_LDMASK = 7;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  // Status and flag fields
  localparam int STAT_PG     = 0;
  localparam int STAT_PPDONE = 1;
  localparam int STAT_LDSTAT = 2;
  localparam int STAT_TYPE   = 4;
  localparam int FLAG_PP     = 0;
  localparam int FLAG_LD     = 1;

  // Current limits in 50 mA steps
  localparam logic [7:0] ILIM_SDP   = 8'h0A;
  localparam logic [7:0] ILIM_CDP   = 8'h1E;
  localparam logic [7:0] ILIM_DCP   = 8'h41;
  localparam logic [7:0] ILIM_HV    = 8'h1E;
  localparam logic [7:0] ILIM_UNK   = 8'h3C;
  localparam logic [7:0] ILIM_DIV1  = 8'h2A;
  localparam logic [7:0] ILIM_DIV2  = 8'h28;
  localparam logic [7:0] ILIM_DIV3  = 8'h14;
  localparam logic [7:0] ILIM_DIV4  = 8'h30;
  localparam logic [7:0] ILIM_RESET = 8'h3C;
  localparam logic [7:0] ILIM_MIN   = 8'h02;

  // Source type codes
  localparam logic [3:0] TYPE_NONE = 4'h0;
  localparam logic [3:0] TYPE_SDP  = 4'h1;
  localparam logic [3:0] TYPE_CDP  = 4'h2;
  localparam logic [3:0] TYPE_DCP  = 4'h3;
  localparam logic [3:0] TYPE_HV   = 4'h4;
  localparam logic [3:0] TYPE_UNK  = 4'h5;
  localparam logic [3:0] TYPE_NSTD = 4'h6;

  // Line drive level codes
  localparam logic [2:0] DRV_HIZ   = 3'h0;
  localparam logic [2:0] DRV_0V0   = 3'h1;
  localparam logic [2:0] DRV_0V6   = 3'h2;
  localparam logic [2:0] DRV_1V2   = 3'h3;
  localparam logic [2:0] DRV_2V0   = 3'h4;
  localparam logic [2:0] DRV_2V7   = 3'h5;
  localparam logic [2:0] DRV_3V3   = 3'h6;
  localparam logic [2:0] DRV_SHORT = 3'h7;

  // Timing
  localparam int CLK_MHZ         = 100;
  localparam int SETTLE_US       = 40;
  localparam int SETTLE_CYC      = SETTLE_US * CLK_MHZ;
  localparam int DCD_TMO_MS      = 600;
  localparam int DCD_TMO_CYC     = DCD_TMO_MS * 1000 * CLK_MHZ;
  localparam int HV_TMO_MS       = 1500;
  localparam int HV_TMO_CYC      = HV_TMO_MS * 1000 * CLK_MHZ;
  localparam int SWITCH_DLY_MS   = 30;
  localparam int SWITCH_DLY_CYC  = SWITCH_DLY_MS * 1000 * CLK_MHZ;

  // Sequencer states
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_DCD  = 8'h02,
    S_PRIM = 8'h04,
    S_DIV  = 8'h08,
    S_SEC  = 8'h10,
    S_HV12 = 8'h20,
    S_HV9  = 8'h40,
    S_WAIT = 8'h80
  } isd_state_e;

endpackage

// ===== verif/isd_adapter_model.sv
// Behavioural USB charging adapter as seen by the line comparators
`timescale 1ns/1ps
module isd_adapter_model (
  // Adapter choice
  input  wire logic       PLUGGED,
  input  wire logic [3:0] KIND,
  // Comparator view
  output logic            CONTACT_CMP,
  output logic            PRIM_CMP,
  output logic            SEC_CMP,
  output logic            HV_ACK,
  output logic      [2:0] DIV_CODE
);
  // Kinds: 0 SDP, 1 CDP, 2 DCP, 3 HV, 4 unknown, 5..8 dividers 1..4
  // Dividers show no data contact so the divider check alone names them
  assign CONTACT_CMP = PLUGGED && (KIND < 4'h4);
  assign PRIM_CMP    = PLUGGED && (KIND inside {4'h1, 4'h2, 4'h3});
  assign SEC_CMP     = PLUGGED && (KIND inside {4'h2, 4'h3});
  assign HV_ACK      = PLUGGED && (KIND == 4'h3);
  assign DIV_CODE    = (PLUGGED && KIND > 4'h4) ? 3'(KIND - 4'h4) : 3'h0;
endmodule

// ===== verif/testbench.sv
// Self-checking bench for input source type detection
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [3:0] kind;
    logic [3:0] code;
    logic [7:0] ilim;
  } isd_row_s;
  logic       CLK = 1'b0;
  logic       ARST_N = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [7:0] WDATA = 8'h00;
  logic       WR = 1'b0;
  logic       RD = 1'b0;
  logic       ATTACH = 1'b0;
  logic       FIRST_ALT_INPUT = 1'b1;
  logic       SRC_QUAL_OK = 1'b1;
  logic [7:0] CLAMP_CODE = 8'hFF;
  logic [3:0] KIND = 4'h0;
  logic [7:0] RDATA, EFF_LIMIT, d;
  logic [2:0] PLUS_DRIVE, MINUS_DRIVE, DIV_CODE;
  logic       SWITCH_EN, INT_PULSE, CONTACT_CMP, PRIM_CMP, SEC_CMP, HV_ACK;
  int         comparisons = 0;
  int         miscompares = 0;
  int         ints = 0;
  int         i0;
  isd_row_s   rows [8] = '{'{4'h0, 4'h1, 8'h0A}, '{4'h1, 4'h2, 8'h1E}, '{4'h2, 4'h3, 8'h41},
    '{4'h4, 4'h5, 8'h3C}, '{4'h5, 4'h6, 8'h2A}, '{4'h6, 4'h6, 8'h28}, '{4'h7, 4'h6, 8'h14},
    '{4'h8, 4'h6, 8'h30}};

  // Short counts keep a full plug cycle just over 8000 clocks
  isd_detect #(.DCD_TMO(50), .HV_TMO(100), .SWITCH_DLY(20)) isd_detect_i (
    .CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SRC_QUAL_OK(SRC_QUAL_OK), .ATTACH(ATTACH),
    .FIRST_ALT_INPUT(FIRST_ALT_INPUT), .CONTACT_CMP(CONTACT_CMP), .PRIM_CMP(PRIM_CMP),
    .SEC_CMP(SEC_CMP), .HV_ACK(HV_ACK), .DIV_CODE(DIV_CODE), .CLAMP_CODE(CLAMP_CODE),
    .PLUS_DRIVE(PLUS_DRIVE), .MINUS_DRIVE(MINUS_DRIVE), .EFF_LIMIT(EFF_LIMIT),
    .SWITCH_EN(SWITCH_EN), .INT_PULSE(INT_PULSE));
  isd_adapter_model isd_adapter_model_i (
    .PLUGGED(ATTACH), .KIND(KIND), .CONTACT_CMP(CONTACT_CMP), .PRIM_CMP(PRIM_CMP),
    .SEC_CMP(SEC_CMP), .HV_ACK(HV_ACK), .DIV_CODE(DIV_CODE));

  always #5 CLK = ~CLK;
  always @(posedge CLK) if (INT_PULSE === 1'b1) ints++;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a; WDATA <= v; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic attach(input logic [3:0] k);
    @(posedge CLK);
    KIND <= k; ATTACH <= 1'b1;
  endtask
  task automatic wait_sw;
    int n;
    n = 0;
    while (SWITCH_EN !== 1'b1 && n < 20000) begin
      @(posedge CLK);
      n++;
    end
    check("switch enable", {7'h00, SWITCH_EN}, 8'h01);
  endtask
  task automatic unplug;
    @(posedge CLK);
    ATTACH <= 1'b0;
    repeat (10) @(posedge CLK);
  endtask

  initial begin
    // Tests need about 89k clocks
    #980000;
    miscompares++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge CLK);
    ARST_N <= 1'b1;
    @(posedge CLK);
    #1 check("reset limit", EFF_LIMIT, 8'h3C);
    rd(isd_pkg::REG_CTRL);
    check("reset ctrl", d, 8'h03);
    rd(4'hF);
    check("unmapped", d, 8'h00);
    // Every table row: type, status, limit, one interrupt and both flags
    foreach (rows[r]) begin
      i0 = ints;
      attach(rows[r].kind);
      wait_sw();
      rd(isd_pkg::REG_STAT);
      check("type", {4'h0, d[7:4]}, {4'h0, rows[r].code});
      check("status", {5'h00, d[2:0]}, 8'h03);
      rd(isd_pkg::REG_ILIM);
      check("limit", d, rows[r].ilim);
      check("int count", 8'(ints - i0), 8'h01);
      rd(isd_pkg::REG_FLAG);
      check("flags", d, 8'h03);
      unplug();
    end
    // Drive levels during and after a run
    attach(4'h0);
    repeat (100) @(posedge CLK);
    wr(isd_pkg::REG_PLUS, 8'h03);
    wait_sw();
    rd(isd_pkg::REG_PLUS);
    check("plus held", d, 8'h00);
    wr(isd_pkg::REG_PLUS, 8'h03);
    rd(isd_pkg::REG_PLUS);
    check("plus level", d, 8'h03);
    check("plus drive", {5'h00, PLUS_DRIVE}, 8'h03);
    wr(isd_pkg::REG_MINUS, 8'h01);
    rd(isd_pkg::REG_MINUS);
    check("minus no 0 V", d, 8'h00);
    wr(isd_pkg::REG_MINUS, 8'h06);
    rd(isd_pkg::REG_MINUS);
    check("minus level", d, 8'h06);
    check("minus drive", {5'h00, MINUS_DRIVE}, 8'h06);
    wr(isd_pkg::REG_PLUS, 8'h00);
    unplug();
    // Second input gets no line detection
    FIRST_ALT_INPUT <= 1'b0;
    attach(4'h0);
    repeat (50) @(posedge CLK);
    rd(isd_pkg::REG_STAT);
    check("line busy", {7'h00, d[2]}, 8'h00);
    unplug();
    FIRST_ALT_INPUT <= 1'b1;
    // Masked events, 9 V only probe that times out and keeps the DCP result
    wr(isd_pkg::REG_CTRL, 8'hCF);
    rd(isd_pkg::REG_FLAG);
    i0 = ints;
    attach(4'h2);
    wait_sw();
    rd(isd_pkg::REG_STAT);
    check("masked type", {4'h0, d[7:4]}, 8'h03);
    check("masked status", {5'h00, d[2:0]}, 8'h03);
    rd(isd_pkg::REG_ILIM);
    check("masked limit", d, 8'h41);
    check("masked ints", 8'(ints - i0), 8'h00);
    rd(isd_pkg::REG_FLAG);
    check("masked flags", d, 8'h00);
    unplug();
    // Both voltage requests with a high voltage adapter
    wr(isd_pkg::REG_CTRL, 8'h1F);
    attach(4'h3);
    wait_sw();
    rd(isd_pkg::REG_STAT);
    check("hv type", {4'h0, d[7:4]}, 8'h04);
    rd(isd_pkg::REG_ILIM);
    check("hv limit", d, 8'h1E);
    wr(isd_pkg::REG_CTRL, 8'h1B);
    unplug();
    // Auto detect off leaves limit and type alone
    wr(isd_pkg::REG_CTRL, 8'h02);
    wr(isd_pkg::REG_ILIM, 8'h11);
    attach(4'h1);
    wait_sw();
    rd(isd_pkg::REG_ILIM);
    check("kept limit", d, 8'h11);
    rd(isd_pkg::REG_STAT);
    check("kept type", {4'h0, d[7:4]}, 8'h04);
    unplug();
    // Pin clamp against a host limit
    wr(isd_pkg::REG_CTRL, 8'h03);
    wr(isd_pkg::REG_ILIM, 8'h30);
    CLAMP_CODE <= 8'h20;
    repeat (4) @(posedge CLK);
    #1 check("clamped", EFF_LIMIT, 8'h20);
    wr(isd_pkg::REG_CTRL, 8'h01);
    repeat (4) @(posedge CLK);
    #1 check("host limit", EFF_LIMIT, 8'h30);
    test_done();
  end
endmodule
